//--- hw/bcswp_pkg.sv
/*
  Constants, types and timing figures for the bus clock select, wait and
  parity pin logic of the external memory interface.
  Assumes one 40 MHz clock (mclk) and a synchronous active-high reset.
*/
// Functional notes
// - Stall request low sampled on bus rising edge
// - Odd byte parity driven during writes
// - Burst continue is inverse of memory request
// - Source select low: bus clock input, inverse low
// - Source select high: device makes bus clocks
// - Ratio select picks one of two sets
// - Undriven ratio select means slower set
// - Bypass high: core uses external core clock
// - Test port timed by its own clock
// - Output bus clock is core over divider plus two
// - Memory request low announces next cycle access
package bcswp_pkg;

  localparam int unsigned DATA_W    = 32;
  localparam int unsigned ADDR_W    = 32;
  localparam int unsigned BYTE_W    = 8;
  localparam int unsigned LANES     = DATA_W / BYTE_W;
  localparam int unsigned DIV_W     = 3;
  localparam int unsigned CNT_W     = 4;
  localparam int unsigned RATIO_W   = 4;
  localparam logic [CNT_W-1:0] DIV_OFFSET = 4'h2;
  localparam logic [RATIO_W-1:0] RATIO_FAST = 4'h6;
  localparam logic [RATIO_W-1:0] RATIO_SLOW = 4'h4;

  // bus access sequencer
  typedef enum logic [1:0] {
    BCSWP_IDLE    = 2'b00,
    BCSWP_ANNOUNCE = 2'b01,
    BCSWP_ACCESS  = 2'b10
  } bcswp_state_t;

endpackage

//--- hw/bcswp_divider.sv
/*
  Divides the core clock rate into a bus clock phase and rising-edge and falling-edge pulses.
  Assumes the divisor only changes while held in reset.
*/
`timescale 1ns/1ps
`default_nettype none
module bcswp_divider
  import bcswp_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic                    enable,
  input  wire logic [bcswp_pkg::DIV_W-1:0] div_sel,
  output var  logic                    clk_level,
  output var  logic                    rise_pulse,
  output var  logic                    fall_pulse
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             level;
    logic             rise;
    logic             fall;
  } bcswp_div_t;

  bcswp_div_t q, d;
  logic [CNT_W-1:0] period;

  // period is divider pins plus two, high for half, low for the rest
  always_comb begin
    period  = {1'b0, div_sel} + DIV_OFFSET;
    d       = q;
    d.rise  = 1'b0;
    d.fall  = 1'b0;
    if (enable) begin
      if (q.cnt >= period - 4'h1) begin
        d.cnt   = '0;
        d.level = 1'b1;
        d.rise  = 1'b1;
      end else begin
        d.cnt = q.cnt + 4'h1;
        if (q.cnt + 4'h1 == (period >> 1)) begin
          d.level = 1'b0;
          d.fall  = 1'b1;
        end
      end
    end else begin
      d.cnt   = '0;
      d.level = 1'b0;
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign clk_level  = q.level;
  assign rise_pulse = q.rise;
  assign fall_pulse = q.fall;

endmodule
`default_nettype wire

//--- hw/bcswp_top.sv
/*
  Pin control of the external memory interface: bus clock source choice,
  divided bus clock outputs, stall sampling, byte parity, request/burst
  strobes and core clock source/ratio choice.
  Assumes all pin inputs are synchronous to mclk, the straps are stable,
  and the test port reset and test clock are handled elsewhere.
*/
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module bcswp_top
  import bcswp_pkg::*;
(
  input  wire logic                        mclk,  // only clock here; test port clock lies outside
  input  wire logic                        rst,
  input  wire logic                        clock_source_select,
  input  wire logic [bcswp_pkg::DIV_W-1:0] bus_clock_divider_pins,
  input  wire logic [1:0]                  core_clock_config_pins,
  input  wire logic                        bus_clock_in,
  input  wire logic                        pll_ratio_select_in,
  input  wire logic                        pll_ratio_select_oe,
  input  wire logic                        pll_bypass_select,
  input  wire logic                        external_core_clock,
  input  wire logic                        pll_clock,
  input  wire logic                        stall_request_low,
  input  wire logic                        req_valid,
  input  wire logic                        req_write,
  input  wire logic [bcswp_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [bcswp_pkg::DATA_W-1:0] req_wdata,
  output var  logic                        req_ready,
  output var  logic                        req_done,
  output var  logic                        bus_clock_out,
  output var  logic                        bus_clock_oe,
  output var  logic                        inverted_bus_clock,
  output var  logic                        memory_request_low,
  output var  logic                        burst_continue,
  output var  logic                        write_not_read,
  output var  logic [bcswp_pkg::ADDR_W-1:0] addr_out,
  output var  logic [bcswp_pkg::DATA_W-1:0] data_out,
  output var  logic                        data_oe,
  output var  logic [bcswp_pkg::LANES-1:0] parity_out,
  output var  logic                        core_clock_sel,
  output var  logic                        pll_ratio_slow,
  output var  logic [bcswp_pkg::RATIO_W-1:0] pll_ratio
);

  typedef struct packed {
    // sequencer and handshake
    bcswp_state_t          st;
    logic                  bin_prev;
    logic                  ready;
    logic                  done;
    // bus clock pins
    logic                  bclk;
    logic                  bclk_oe;
    logic                  nbclk;
    // memory side pins
    logic                  mreq_n;
    logic                  seq;
    logic                  wr;
    logic [ADDR_W-1:0]     addr;
    logic [DATA_W-1:0]     data;
    logic                  doe;
    logic [LANES-1:0]      par;
    // core clock choice
    logic                  core_sel;
    logic                  slow;
    logic [RATIO_W-1:0]    ratio;
  } bcswp_regs_t;

  // q is the registered state, d its next value
  bcswp_regs_t q, d;

  // bus clock events seen by the sequencer
  logic div_level;
  logic div_rise;
  logic div_fall;
  logic bus_rise;
  logic bus_fall;
  logic bus_high;
  logic ratio_pin;

  // odd parity per byte: bit i over bits 8i+7..8i
  function automatic logic [LANES-1:0] odd_parity(input logic [DATA_W-1:0] v);
    logic [LANES-1:0] p;
    p = '0;
    // one bit per byte lane; inverted xor makes the lane odd
    for (int i = 0; i < LANES; i++) begin
      p[i] = ~^v[i*BYTE_W +: BYTE_W];
    end
    return p;
  endfunction

  // bus clock generator when the device owns the bus clock
  bcswp_divider u_div (
    .mclk       (mclk),
    .rst        (rst),
    .enable     (clock_source_select),
    .div_sel    (bus_clock_divider_pins),
    .clk_level  (div_level),
    .rise_pulse (div_rise),
    .fall_pulse (div_fall)
  );

  // bus clock edges from either source; source select is a fixed strap
  // input clock edges come from a one-cycle-old copy of the pin
  always_comb begin
    if (clock_source_select) begin
      bus_rise = div_rise;
      bus_fall = div_fall;
      bus_high = div_level;
    end else begin
      bus_rise = bus_clock_in & ~q.bin_prev;
      bus_fall = ~bus_clock_in & q.bin_prev;
      bus_high = bus_clock_in;
    end
  end

  // undriven ratio pin reads as pulled high
  assign ratio_pin = pll_ratio_select_oe ? pll_ratio_select_in : 1'b1;

  // next state of all pin registers
  always_comb begin
    d          = q;
    d.done     = 1'b0;
    d.bin_prev = bus_clock_in;
    // bus clock pins
    d.bclk_oe  = clock_source_select;
    d.bclk     = clock_source_select & div_level;
    d.nbclk    = clock_source_select & ~div_level;
    // core clock source and ratio set
    d.core_sel = pll_bypass_select ? external_core_clock : pll_clock;
    d.slow     = ratio_pin;
    d.ratio    = (ratio_pin ? RATIO_SLOW : RATIO_FAST) + {2'b00, core_clock_config_pins};
    // burst continue tracks the request, updated while bus clock is high
    if (bus_high) begin
      d.seq = ~q.mreq_n;
    end
    // access sequencer, in bus clock events:
    //   idle      take the request, latch address, data and direction
    //   announce  request low after the next bus clock fall
    //   access    first unstalled rise ends the announce cycle
    //             data drive and parity follow a fall on writes
    //             second unstalled rise completes and frees the port
    //   a low stall request on a rise leaves the request, data and parity pins as they are
    unique case (q.st)
      BCSWP_IDLE: begin
        d.ready = 1'b1;
        if (req_valid && q.ready) begin
          d.ready = 1'b0;
          d.addr  = req_addr;
          d.wr    = req_write;
          d.data  = req_wdata;
          d.st    = BCSWP_ANNOUNCE;
        end
      end
      BCSWP_ANNOUNCE: begin
        // request low while bus clock low, one cycle ahead of the access
        if (bus_fall) begin
          d.mreq_n = 1'b0;
          d.st     = BCSWP_ACCESS;
        end
      end
      BCSWP_ACCESS: begin
        if (bus_fall) begin
          d.doe = q.wr;
          d.par = q.wr ? odd_parity(q.data) : '0;
        end
        // stall sampled on the rising edge; outputs held while low
        if (bus_rise && stall_request_low && !q.mreq_n) begin
          d.mreq_n = 1'b1;
        end else if (bus_rise && stall_request_low && q.mreq_n) begin
          d.done  = 1'b1;
          d.doe   = 1'b0;
          d.ready = 1'b1;
          d.st    = BCSWP_IDLE;
        end
      end
      default: begin
        d.st = BCSWP_IDLE;
      end
    endcase
  end

  // register everything
  always_ff @(posedge mclk) begin
    if (rst) begin
      // request idle high, slow flag set and ratio value zero until the pin is seen
      q        <= '0;
      q.st     <= BCSWP_IDLE;
      q.mreq_n <= 1'b1;
      q.slow   <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // handshake to the core side
  assign req_ready          = q.ready;
  assign req_done           = q.done;

  // bus clock pins
  assign bus_clock_out      = q.bclk;
  assign bus_clock_oe       = q.bclk_oe;
  assign inverted_bus_clock = q.nbclk;

  // memory strobes, address and data
  assign memory_request_low = q.mreq_n;
  assign burst_continue     = q.seq;
  assign write_not_read     = q.wr;
  assign addr_out           = q.addr;
  assign data_out           = q.data;
  assign data_oe            = q.doe;
  assign parity_out         = q.par;

  // core clock source and ratio set
  assign core_clock_sel     = q.core_sel;
  assign pll_ratio_slow     = q.slow;
  assign pll_ratio          = q.ratio;

endmodule
`default_nettype wire

//--- tb/bcswp_monitor.sv
/* checker of bcswp_top pin behaviour
   assumes bind onto bcswp_top, mclk and sync rst */
`timescale 1ns/1ps
`default_nettype none
module bcswp_monitor
  import bcswp_pkg::*;
(
  input wire logic                           mclk,
  input wire logic                           rst,
  input wire logic                           clock_source_select,
  input wire logic [bcswp_pkg::DIV_W-1:0]    bus_clock_divider_pins,
  input wire logic                           stall_request_low,
  input wire logic                           req_ready,
  input wire logic                           req_done,
  input wire logic                           bus_clock_out,
  input wire logic                           bus_clock_oe,
  input wire logic                           inverted_bus_clock,
  input wire logic                           memory_request_low,
  input wire logic                           burst_continue,
  input wire logic                           write_not_read,
  input wire logic [bcswp_pkg::DATA_W-1:0]   data_out,
  input wire logic                           data_oe,
  input wire logic [bcswp_pkg::LANES-1:0]    parity_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic [3:0] per_q;
  logic       prv_q;
  logic       seen_q;
  logic [3:0] exp_par;
  // cycles since the last bus clock rise
  always_ff @(posedge mclk) begin
    prv_q <= bus_clock_out;
    per_q <= (bus_clock_out && !prv_q) ? 4'h1 : per_q + 4'h1;
    seen_q <= rst ? 1'b0 : (seen_q || (bus_clock_out && !prv_q));
  end
  // odd parity per byte
  always_comb for (int i = 0; i < 4; i++) exp_par[i] = ~^data_out[8*i +: 8];
  sequence s_stall; $rose(bus_clock_out) && !stall_request_low && !req_ready; endsequence
  sequence s_held; $stable(memory_request_low) && $stable(data_out) && !req_done; endsequence
  sequence s_no_done; !req_done [*2]; endsequence
  property p_period;
    clock_source_select && seen_q && bus_clock_out && !prv_q
      |-> per_q == {1'b0, bus_clock_divider_pins} + DIV_OFFSET;
  endproperty
  property p_hold; s_stall |-> s_held ##1 s_no_done; endproperty
  property p_done; req_done |-> req_ready && !data_oe && memory_request_low; endproperty
  property p_par; data_oe && write_not_read |-> parity_out == exp_par; endproperty
  property p_oe; !$past(rst) |-> bus_clock_oe == $past(clock_source_select); endproperty
  property p_inv; !clock_source_select && !$past(rst) |-> !inverted_bus_clock; endproperty
  property p_cmp; clock_source_select && !$past(rst) |-> inverted_bus_clock != bus_clock_out; endproperty
  property p_seq; $stable(memory_request_low) [*8] |-> burst_continue == !memory_request_low; endproperty
  property p_busy; !memory_request_low |-> !req_ready; endproperty
  a_period: assert property (p_period) else $error("bus clock period wrong");
  a_hold: assert property (p_hold) else $error("access ended under stall");
  a_done: assert property (p_done) else $error("bad state at access end");
  a_par: assert property (p_par) else $error("write parity wrong");
  a_oe: assert property (p_oe) else $error("bus clock enable wrong");
  a_inv: assert property (p_inv) else $error("inverse clock not low");
  a_cmp: assert property (p_cmp) else $error("inverse clock not inverse");
  a_seq: assert property (p_seq) else $error("burst not inverse of request");
  a_busy: assert property (p_busy) else $error("request while idle");
endmodule
bind bcswp_top bcswp_monitor u_mon (.*);
`default_nettype wire

//--- tb/bcswp_mem_model.sv
/* memory side model: stalls each access a set number of bus edges
   assumes bus clock level and request from the block */
`timescale 1ns/1ps
`default_nettype none
module bcswp_mem_model (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       bus_clk,
  input  wire logic       memory_request_low,
  input  wire logic [1:0] stalls,
  output var  logic       stall_request_low
);
  logic [1:0] cnt_q;
  logic       prv_q;
  logic       req_q;
  // load count as request falls, spend one per bus clock rise
  always_ff @(posedge mclk) begin
    prv_q <= bus_clk;
    req_q <= memory_request_low;
    if (rst) cnt_q <= 2'h0;
    else if (req_q && !memory_request_low) cnt_q <= stalls;
    else if (bus_clk && !prv_q && cnt_q != 2'h0) cnt_q <= cnt_q - 2'h1;
  end
  assign stall_request_low = (cnt_q == 2'h0);
endmodule
`default_nettype wire

//--- tb/test_bcswp_top.sv
/* self-checking bench of bcswp_top
   assumes the monitor bind and the memory model */
`timescale 1ns/1ps
`default_nettype none
module test_bcswp_top;
  import bcswp_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, clock_source_select = 1'b1, bus_clock_in = 1'b0;
  logic pll_ratio_select_in = 1'b0, pll_ratio_select_oe = 1'b0, pll_bypass_select = 1'b0;
  logic external_core_clock = 1'b0, pll_clock = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic [DIV_W-1:0] bus_clock_divider_pins = 3'h3;
  logic [1:0] core_clock_config_pins = 2'h0, stalls = 2'h0;
  logic [ADDR_W-1:0] req_addr = '0, addr_out;
  logic [DATA_W-1:0] req_wdata = '0, data_out;
  logic [LANES-1:0] parity_out;
  logic [RATIO_W-1:0] pll_ratio;
  logic req_ready, req_done, bus_clock_out, bus_clock_oe, inverted_bus_clock, stall_request_low;
  logic memory_request_low, burst_continue, write_not_read, data_oe, core_clock_sel, pll_ratio_slow;
  int fails = 0, cmp_count = 0;
  bcswp_top uut (.*);
  bcswp_mem_model u_mem (.mclk(mclk), .rst(rst), .bus_clk(clock_source_select ? bus_clock_out : bus_clock_in),
    .memory_request_low(memory_request_low), .stalls(stalls), .stall_request_low(stall_request_low));
  // clocks: mclk and an input bus clock of six cycles
  always #12.5 mclk = ~mclk;  // single block clock
  always begin
    repeat (3) @(posedge mclk);
    bus_clock_in <= ~bus_clock_in;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wait_hi(ref logic s, input logic v = 1'b1);
    int k;
    k = 0;
    while (s !== v && k < 80) begin
      @(posedge mclk);
      #1;
      k++;
    end
    if (s !== v) fails++;
  endtask
  task automatic do_reset;
    rst <= 1'b1;  // block reset stands in for the test-port reset too
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    wait_hi(req_ready);
  endtask
  // one access with n stalled bus edges
  task automatic access(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [1:0] n);
    logic [3:0] p;
    for (int i = 0; i < 4; i++) p[i] = ~^d[8*i +: 8];
    @(posedge mclk);
    {req_valid, req_write, req_addr, req_wdata, stalls} <= {1'b1, wr, a, d, n};
    @(posedge mclk);
    req_valid <= 1'b0;
    wait_hi(memory_request_low, 1'b0);
    chk(req_ready, 1'b0);
    chk(burst_continue, 1'b0);
    if (wr) wait_hi(data_oe);
    if (wr) chk(parity_out, p);
    if (wr) chk(data_out, d);
    if (wr) chk(bus_clock_out, 1'b0);
    if (wr) chk(inverted_bus_clock, clock_source_select);
    wait_hi(req_done);
    chk(addr_out, a);
    chk(write_not_read, wr);
    chk(memory_request_low, 1'b1);
    chk(burst_continue, 1'b0);
  endtask
  task automatic t_writes;
    logic [31:0] pat [4] = '{32'h0, 32'hffffffff, 32'h01020304, 32'h80ff7f00};
    for (int i = 0; i < 4; i++) access(1'b1, 32'h100 + i, pat[i], i[1:0]);
    access(1'b0, 32'h200, 32'h0, 2'h2);
    $display("writes and read done");
  endtask
  task automatic t_straps;
    logic s;
    for (int j = 0; j < 4; j++) begin
      @(posedge mclk);
      {pll_ratio_select_oe, pll_ratio_select_in, pll_bypass_select} <= {j[0], j[1], j[0]};
      {external_core_clock, pll_clock, core_clock_config_pins} <= {j[0], j[1], j[1:0]};
      repeat (3) @(posedge mclk);
      #1;
      s = !j[0] || j[1];
      chk(pll_ratio_slow, s);
      chk(pll_ratio, (s ? RATIO_SLOW : RATIO_FAST) + j[1:0]);
      chk(core_clock_sel, j[0] | j[1]);
    end
    $display("straps done");
  endtask
  task automatic t_select;
    @(posedge mclk);
    clock_source_select <= 1'b0;  // changed only under reset
    do_reset;
    chk(bus_clock_oe, 1'b0);
    chk(inverted_bus_clock, 1'b0);
    access(1'b1, 32'h300, 32'h5a5a0f0f, 2'h1);
    @(posedge mclk);
    clock_source_select <= 1'b1;  // changed only under reset
    bus_clock_divider_pins <= 3'h7;
    do_reset;
    chk(bus_clock_oe, 1'b1);
    access(1'b1, 32'h304, 32'h12345678, 2'h3);
    $display("clock select done");
  endtask
  // watchdog
  initial begin
    #200000;
    fails++;
    wrap_up;
  end
  initial begin
    do_reset;
    t_writes;
    t_straps;
    t_select;
    wrap_up;
  end
endmodule
`default_nettype wire
